/* File: design/mrre_exec.sv */
// Execution unit for moves, returns, rotates and subtract with borrow.
// Notes on behaviour
// - Immediate move loads literal, flags kept.
// - Store writes accumulator to memory, flags kept.
// - Subroutine exit pops PC, two cycles, flags kept.
// - Exit with literal pops PC, loads accumulator.
// - Memory left rotate through carry, written back.
// - Accumulator left rotate through carry, memory kept.
// - Memory right rotate, carry kept, written back.
// - Right rotate into accumulator, memory kept.
// - Memory right rotate through carry, written back.
`timescale 1ns/1ps
`default_nettype none
module mrre_exec
    import mrre_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            resetn,
    input  wire logic            clk_en,
    input  wire logic            req_valid,
    input  wire mrre_req_s       req,
    input  wire logic [PC_W-1:0] stack_top,
    output logic                 req_ready_q,
    output logic [7:0]           acc_q,
    output mrre_flags_s          flags_q,
    output logic                 mem_we_q,
    output logic [7:0]           mem_wdata_q,
    output logic                 stack_pop_q,
    output logic                 pc_load_q,
    output logic [PC_W-1:0]      pc_value_q,
    output logic                 global_irq_enable_q
);

    mrre_state_e     state_q, state_d;
    logic            req_ready_d;
    logic [7:0]      acc_d;
    mrre_flags_s     flags_d;
    logic            mem_we_d;
    logic [7:0]      mem_wdata_d;
    logic            stack_pop_d;
    logic            pc_load_d;
    logic [PC_W-1:0] pc_value_d;
    logic            gie_d;
    logic            accept;
    mrre_rot_e       rot_mode;
    logic [7:0]      rot_data;
    logic            rot_carry;
    logic [8:0]      sub_sum;
    logic [4:0]      sub_low;
    logic [7:0]      mem_inv;

    // Every check below runs on the one clock and sleeps during reset.
    default clocking mrre_cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    assign accept  = req_valid && req_ready_q && clk_en;
    assign mem_inv = ~req.mem;

    // Pick the rotate flavour from the opcode; non-rotates ignore it.
    always_comb begin
        case (req.op)
            OP_ROTATE_LEFT_THRU_CARRY:   rot_mode = ROT_LEFT_CARRY;
            OP_ROTATE_LEFT_CARRY_TO_ACC: rot_mode = ROT_LEFT_CARRY;
            OP_ROTATE_RIGHT:             rot_mode = ROT_RIGHT;
            OP_ROTATE_RIGHT_TO_ACC:      rot_mode = ROT_RIGHT;
            OP_ROTATE_RIGHT_THRU_CARRY:  rot_mode = ROT_RIGHT_CARRY;
            default:                     rot_mode = ROT_RIGHT;
        endcase
    end

    mrre_rotator u_rot (
        .data_in   (req.mem),
        .carry_in  (flags_q.carry_flag),
        .mode      (rot_mode),
        .data_out  (rot_data),
        .carry_out (rot_carry)
    );

    // Subtraction is done as addition of the complement plus carry.
    always_comb begin
        sub_sum = {1'b0, acc_q} + {1'b0, mem_inv}
                + {8'h00, flags_q.carry_flag};
        sub_low = {1'b0, acc_q[3:0]} + {1'b0, mem_inv[3:0]}
                + {4'h0, flags_q.carry_flag};
    end

    // Next-state logic; write and stack strobes fall back to zero each
    // enabled cycle so that each lasts exactly one enabled cycle.
    always_comb begin
        state_d     = state_q;
        req_ready_d = req_ready_q;
        acc_d       = acc_q;
        flags_d     = flags_q;
        mem_we_d    = mem_we_q;
        mem_wdata_d = mem_wdata_q;
        stack_pop_d = stack_pop_q;
        pc_load_d   = pc_load_q;
        pc_value_d  = pc_value_q;
        gie_d       = global_irq_enable_q;
        if (clk_en) begin
            mem_we_d    = 1'b0;
            stack_pop_d = 1'b0;
            pc_load_d   = 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        case (req.op)
                            OP_MOV_IMM: acc_d = req.imm;
                            OP_STORE_ACC: begin
                                mem_we_d    = 1'b1;
                                mem_wdata_d = acc_q;
                            end
                            OP_SUBROUTINE_EXIT,
                            OP_SUBROUTINE_EXIT_LIT,
                            OP_INTERRUPT_EXIT: begin
                                // First of two cycles: pop and hold.
                                stack_pop_d = 1'b1;
                                pc_value_d  = stack_top;
                                state_d     = ST_EXIT;
                                req_ready_d = 1'b0;
                                if (req.op == OP_SUBROUTINE_EXIT_LIT) begin
                                    acc_d = req.imm;
                                end
                                if (req.op == OP_INTERRUPT_EXIT) begin
                                    gie_d = 1'b1;
                                end
                            end
                            OP_ROTATE_LEFT_THRU_CARRY,
                            OP_ROTATE_RIGHT_THRU_CARRY: begin
                                mem_we_d           = 1'b1;
                                mem_wdata_d        = rot_data;
                                flags_d.carry_flag = rot_carry;
                            end
                            OP_ROTATE_RIGHT: begin
                                mem_we_d    = 1'b1;
                                mem_wdata_d = rot_data;
                            end
                            OP_ROTATE_LEFT_CARRY_TO_ACC: begin
                                acc_d              = rot_data;
                                flags_d.carry_flag = rot_carry;
                            end
                            OP_ROTATE_RIGHT_TO_ACC: acc_d = rot_data;
                            OP_SUBTRACT_WITH_BORROW: begin
                                acc_d                   = sub_sum[7:0];
                                flags_d.carry_flag      = sub_sum[8];
                                flags_d.half_carry_flag = sub_low[HALF_POS];
                                flags_d.zero_flag       = ~|sub_sum[7:0];
                                flags_d.signed_wrap_flag =
                                    (acc_q[SIGN_POS] == mem_inv[SIGN_POS])
                                    && (sub_sum[SIGN_POS]
                                        != acc_q[SIGN_POS]);
                            end
                            default: acc_d = acc_q;
                        endcase
                    end
                end
                ST_EXIT: begin
                    // Second cycle: the popped address goes to the PC.
                    pc_load_d   = 1'b1;
                    state_d     = ST_IDLE;
                    req_ready_d = 1'b1;
                end
                default: begin
                    state_d     = ST_IDLE;
                    req_ready_d = 1'b1;
                end
            endcase
        end
    end

    // Registers only; a low clock enable holds every strobe as it stands.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_q             <= ST_IDLE;
            req_ready_q         <= 1'b1;
            acc_q               <= ACC_RST;
            flags_q             <= {4{FLAG_RST}};
            mem_we_q            <= 1'b0;
            mem_wdata_q         <= ACC_RST;
            stack_pop_q         <= 1'b0;
            pc_load_q           <= 1'b0;
            pc_value_q          <= PC_RST;
            global_irq_enable_q <= GIE_RST;
        end else begin
            state_q             <= state_d;
            req_ready_q         <= req_ready_d;
            acc_q               <= acc_d;
            flags_q             <= flags_d;
            mem_we_q            <= mem_we_d;
            mem_wdata_q         <= mem_wdata_d;
            stack_pop_q         <= stack_pop_d;
            pc_load_q           <= pc_load_d;
            pc_value_q          <= pc_value_d;
            global_irq_enable_q <= gie_d;
        end
    end

    sequence s_take(mrre_op_e o);
        accept && (req.op == o);
    endsequence

    sequence s_exit_take;
        accept && (req.op inside {OP_SUBROUTINE_EXIT,
                                  OP_SUBROUTINE_EXIT_LIT,
                                  OP_INTERRUPT_EXIT});
    endsequence

    property p_mov_imm;
        s_take(OP_MOV_IMM) |=> (acc_q == $past(req.imm))
            && (flags_q == $past(flags_q)) && !mem_we_q;
    endproperty
    a_mov_imm: assert property (p_mov_imm)
        else $error("immediate move did not load the accumulator");
    property p_store;
        s_take(OP_STORE_ACC) |=> mem_we_q
            && (mem_wdata_q == $past(acc_q))
            && (flags_q == $past(flags_q));
    endproperty
    a_store: assert property (p_store)
        else $error("store did not write the accumulator");
    property p_exit_pop;
        s_exit_take |=> stack_pop_q && !req_ready_q && !pc_load_q
            && (pc_value_q == $past(stack_top))
            && (flags_q == $past(flags_q));
    endproperty
    a_exit_pop: assert property (p_exit_pop)
        else $error("return did not pop in its first cycle");
    property p_exit_two;
        s_exit_take ##1 clk_en |=> pc_load_q && !stack_pop_q && req_ready_q;
    endproperty
    a_exit_two: assert property (p_exit_two)
        else $error("return did not finish in its second cycle");
    property p_exit_lit;
        s_take(OP_SUBROUTINE_EXIT_LIT) |=> stack_pop_q
            && (acc_q == $past(req.imm));
    endproperty
    a_exit_lit: assert property (p_exit_lit)
        else $error("literal return did not load the accumulator");
    property p_rol_carry_mem;
        s_take(OP_ROTATE_LEFT_THRU_CARRY) |=> mem_we_q
            && (mem_wdata_q == {$past(req.mem[6:0]),
                                $past(flags_q.carry_flag)})
            && (flags_q.carry_flag == $past(req.mem[7]));
    endproperty
    a_rol_carry_mem: assert property (p_rol_carry_mem)
        else $error("memory left rotate through carry is wrong");
    property p_rol_carry_acc;
        s_take(OP_ROTATE_LEFT_CARRY_TO_ACC) |=> !mem_we_q
            && (acc_q == {$past(req.mem[6:0]), $past(flags_q.carry_flag)})
            && (flags_q.carry_flag == $past(req.mem[7]));
    endproperty
    a_rol_carry_acc: assert property (p_rol_carry_acc)
        else $error("accumulator left rotate through carry is wrong");
    property p_ror_mem;
        s_take(OP_ROTATE_RIGHT) |=> mem_we_q
            && (mem_wdata_q == {$past(req.mem[0]), $past(req.mem[7:1])})
            && $stable(flags_q);
    endproperty
    a_ror_mem: assert property (p_ror_mem)
        else $error("memory right rotate is wrong");
    property p_ror_acc;
        s_take(OP_ROTATE_RIGHT_TO_ACC) |=> !mem_we_q
            && (acc_q == {$past(req.mem[0]), $past(req.mem[7:1])});
    endproperty
    a_ror_acc: assert property (p_ror_acc)
        else $error("right rotate into accumulator is wrong");
    property p_ror_carry_mem;
        s_take(OP_ROTATE_RIGHT_THRU_CARRY) |=> mem_we_q
            && (mem_wdata_q == {$past(flags_q.carry_flag),
                                $past(req.mem[7:1])})
            && (flags_q.carry_flag == $past(req.mem[0]));
    endproperty
    a_ror_carry_mem: assert property (p_ror_carry_mem)
        else $error("memory right rotate through carry is wrong");
    property p_sub_borrow;
        s_take(OP_SUBTRACT_WITH_BORROW) |=>
            ({flags_q.carry_flag, acc_q} == 9'({1'b0, $past(acc_q)}
                + {1'b0, ~$past(req.mem)}
                + {8'h00, $past(flags_q.carry_flag)}))
            && (flags_q.zero_flag == (acc_q == 8'h00));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow)
        else $error("subtract with borrow result or flags wrong");
    property p_irq_exit;
        s_take(OP_INTERRUPT_EXIT) ##1 clk_en |-> global_irq_enable_q
            && stack_pop_q ##1 pc_load_q && global_irq_enable_q;
    endproperty
    a_irq_exit: assert property (p_irq_exit)
        else $error("interrupt exit did not enable interrupts");

endmodule
`default_nettype wire

/* File: design/mrre_pkg.sv */
// Shared constants, enumerations and carriers of the move, return and rotate execution unit.
package mrre_pkg;

    localparam int          DATA_W     = 8;
    localparam int          PC_W       = 13;
    localparam int          EXIT_CYCLES = 2;
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic [12:0] PC_RST     = 13'h0000;
    localparam logic        GIE_RST    = 1'b0;
    localparam logic        FLAG_RST   = 1'b0;
    localparam int          HALF_POS   = 4;
    localparam int          SIGN_POS   = 7;

    typedef enum logic [3:0] {
        OP_MOV_IMM              = 4'h0,
        OP_STORE_ACC            = 4'h1,
        OP_SUBROUTINE_EXIT      = 4'h2,
        OP_SUBROUTINE_EXIT_LIT  = 4'h3,
        OP_INTERRUPT_EXIT       = 4'h4,
        OP_ROTATE_LEFT_THRU_CARRY = 4'h5,
        OP_ROTATE_LEFT_CARRY_TO_ACC = 4'h6,
        OP_ROTATE_RIGHT         = 4'h7,
        OP_ROTATE_RIGHT_TO_ACC  = 4'h8,
        OP_ROTATE_RIGHT_THRU_CARRY = 4'h9,
        OP_SUBTRACT_WITH_BORROW = 4'ha
    } mrre_op_e;

    typedef enum logic [1:0] {
        ROT_LEFT_CARRY  = 2'b00,
        ROT_RIGHT       = 2'b01,
        ROT_RIGHT_CARRY = 2'b10
    } mrre_rot_e;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXIT = 1'b1
    } mrre_state_e;

    typedef struct packed {
        mrre_op_e    op;
        logic [7:0]  imm;
        logic [7:0]  mem;
    } mrre_req_s;

    typedef struct packed {
        logic signed_wrap_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } mrre_flags_s;

endpackage

/* File: design/mrre_rotator.sv */
// Combinational one-place byte rotator, with or without the carry in the ring.
`timescale 1ns/1ps
`default_nettype none
module mrre_rotator
    import mrre_pkg::*;
(
    input  wire logic [7:0] data_in,
    input  wire logic       carry_in,
    input  wire mrre_rot_e  mode,
    output logic [7:0]      data_out,
    output logic            carry_out
);

    // The carry leaves unchanged for the plain right rotate.
    always_comb begin
        data_out  = data_in;
        carry_out = carry_in;
        case (mode)
            ROT_LEFT_CARRY: begin
                data_out  = {data_in[6:0], carry_in};
                carry_out = data_in[7];
            end
            ROT_RIGHT: begin
                data_out  = {data_in[0], data_in[7:1]};
                carry_out = carry_in;
            end
            ROT_RIGHT_CARRY: begin
                data_out  = {carry_in, data_in[7:1]};
                carry_out = data_in[0];
            end
            default: begin
                data_out  = data_in;
                carry_out = carry_in;
            end
        endcase
    end

endmodule
`default_nettype wire

/* File: tb/mrre_testbench.sv */
// Self-checking testbench of the move, return and rotate execution unit.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mrre_pkg::*;
;
    logic            clock;
    logic            resetn;
    logic            clk_en;
    logic            req_valid;
    mrre_req_s       req;
    logic [PC_W-1:0] stack_top;
    logic            ready;
    logic [7:0]      acc;
    mrre_flags_s     flags;
    logic            mem_we;
    logic [7:0]      mem_wdata;
    logic            stack_pop;
    logic            pc_load;
    logic [PC_W-1:0] pc_value;
    logic            gie;
    int              err_count;
    int              check_count;
    // Expected architectural state, worked out beside the design.
    logic [7:0]      exp_acc;
    mrre_flags_s     exp_fl;
    logic [7:0]      exp_wd;
    logic            exp_gie;

    mrre_exec dut_u (
        .clock              (clock),
        .resetn             (resetn),
        .clk_en             (clk_en),
        .req_valid          (req_valid),
        .req                (req),
        .stack_top          (stack_top),
        .req_ready_q        (ready),
        .acc_q              (acc),
        .flags_q            (flags),
        .mem_we_q           (mem_we),
        .mem_wdata_q        (mem_wdata),
        .stack_pop_q        (stack_pop),
        .pc_load_q          (pc_load),
        .pc_value_q         (pc_value),
        .global_irq_enable_q(gie)
    );

    // Free-running 200 MHz clock.
    always #2.5 clock = ~clock;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Compares accumulator, flags, write and pop strobes, interrupt enable and, on a write, write data with the expected state.
    task automatic check_state(input logic we, input logic pop);
        chk(acc, exp_acc, "accumulator");
        chk(flags, exp_fl, "flags");
        chk(mem_we, we, "memory write strobe");
        chk(stack_pop, pop, "stack pop strobe");
        chk(gie, exp_gie, "interrupt enable");
        if (we)
            chk(mem_wdata, exp_wd, "memory write data");
    endtask

    // Offers one request, drops it after the accept edge, then lets the
    // results settle so cycle one of the answer is sampled.
    task automatic exec(input mrre_op_e op, input logic [7:0] imm,
                        input logic [7:0] mem, input logic [PC_W-1:0] st);
        @(posedge clock);
        req_valid <= 1'b1;
        req       <= '{op: op, imm: imm, mem: mem};
        stack_top <= st;
        @(posedge clock);
        req_valid <= 1'b0;
        #1;
    endtask

    task automatic test_reset();
        check_state(1'b0, 1'b0);
        chk(ready, 1'b1, "ready after reset");
        chk(pc_load, 1'b0, "pc load after reset");
        chk(pc_value, PC_RST, "pc value after reset");
        $display("test reset done");
    endtask

    // Every rotate against several operands; the carry chains through.
    task automatic test_rotates();
        logic [7:0] mv [4] = '{8'h81, 8'h7e, 8'h01, 8'hc0};
        logic       c;
        logic       we;
        mrre_op_e   op;
        foreach (mv[k]) begin
            for (int o = 5; o <= 9; o++) begin
                op = mrre_op_e'(o[3:0]);
                c  = exp_fl.carry_flag;
                we = 1'b1;
                case (op)
                    OP_ROTATE_LEFT_THRU_CARRY: begin
                        exp_wd = {mv[k][6:0], c};
                        exp_fl.carry_flag = mv[k][7];
                    end
                    OP_ROTATE_LEFT_CARRY_TO_ACC: begin
                        exp_acc = {mv[k][6:0], c};
                        exp_fl.carry_flag = mv[k][7];
                        we = 1'b0;
                    end
                    OP_ROTATE_RIGHT: exp_wd = {mv[k][0], mv[k][7:1]};
                    OP_ROTATE_RIGHT_TO_ACC: begin
                        exp_acc = {mv[k][0], mv[k][7:1]};
                        we = 1'b0;
                    end
                    default: begin
                        exp_wd = {c, mv[k][7:1]};
                        exp_fl.carry_flag = mv[k][0];
                    end
                endcase
                exec(op, 8'h00, mv[k], 13'h0000);
                check_state(we, 1'b0);
            end
        end
        $display("test rotates done");
    endtask

    // Vectors reach zero, borrow, signed wrap and half carry.
    task automatic test_subtract();
        logic [7:0] av [4] = '{8'h10, 8'h50, 8'h00, 8'h80};
        logic [7:0] mv [4] = '{8'h10, 8'hb0, 8'hff, 8'h01};
        logic [8:0] sum;
        logic [4:0] low;
        exp_acc = {7'h00, exp_fl.carry_flag};
        exp_fl.carry_flag = 1'b1;
        exec(OP_ROTATE_LEFT_CARRY_TO_ACC, 8'h00, 8'h80, 13'h0000);
        check_state(1'b0, 1'b0);
        foreach (av[k]) begin
            exec(OP_MOV_IMM, av[k], 8'h00, 13'h0000);
            sum = {1'b0, av[k]} + {1'b0, ~mv[k]} + 9'(exp_fl.carry_flag);
            low = {1'b0, av[k][3:0]} + {1'b0, ~mv[k][3:0]}
                + 5'(exp_fl.carry_flag);
            exp_acc = sum[7:0];
            exp_fl.carry_flag = sum[8];
            exp_fl.half_carry_flag = low[4];
            exp_fl.zero_flag = (sum[7:0] == 8'h00);
            exp_fl.signed_wrap_flag = (av[k][7] != mv[k][7])
                                   && (sum[7] != av[k][7]);
            exec(OP_SUBTRACT_WITH_BORROW, 8'h00, mv[k], 13'h0000);
            check_state(1'b0, 1'b0);
        end
        $display("test subtract done");
    endtask

    // Runs with nonzero flags, so any disturbance of them shows.
    task automatic test_moves();
        exp_acc = 8'h5a;
        exec(OP_MOV_IMM, 8'h5a, 8'h00, 13'h0000);
        check_state(1'b0, 1'b0);
        exp_wd = 8'h5a;
        exec(OP_STORE_ACC, 8'h00, 8'h33, 13'h0000);
        check_state(1'b1, 1'b0);
        @(posedge clock);
        #1;
        chk(mem_we, 1'b0, "write strobe after one cycle");
        $display("test moves done");
    endtask

    task automatic test_returns();
        mrre_op_e ops [3] = '{OP_SUBROUTINE_EXIT, OP_SUBROUTINE_EXIT_LIT,
                              OP_INTERRUPT_EXIT};
        logic [PC_W-1:0] st;
        foreach (ops[k]) begin
            st = PC_W'(13'h1a5c + k);
            if (ops[k] == OP_SUBROUTINE_EXIT_LIT)
                exp_acc = 8'hc3;
            if (ops[k] == OP_INTERRUPT_EXIT)
                exp_gie = 1'b1;
            exec(ops[k], 8'hc3, 8'h00, st);
            check_state(1'b0, 1'b1);
            chk(pc_value, st, "popped address");
            chk(ready, 1'b0, "ready in first cycle");
            chk(pc_load, 1'b0, "early pc load");
            @(posedge clock);
            #1;
            chk(stack_pop, 1'b0, "single pop");
            chk(pc_load, 1'b1, "pc load");
            chk(ready, 1'b1, "ready after return");
        end
        $display("test returns done");
    endtask

    // A frozen clock enable must hold the strobe and refuse requests;
    // an unknown opcode must change nothing.
    task automatic test_freeze();
        // The store below copies whatever the accumulator holds now.
        exp_wd = exp_acc;
        @(posedge clock);
        req_valid <= 1'b1;
        req       <= '{op: OP_STORE_ACC, imm: 8'h00, mem: 8'h00};
        @(posedge clock);
        req_valid <= 1'b0;
        clk_en    <= 1'b0;
        exec(OP_MOV_IMM, 8'h11, 8'h00, 13'h0000);
        check_state(1'b1, 1'b0);
        @(posedge clock);
        clk_en <= 1'b1;
        @(posedge clock);
        #1;
        chk(mem_we, 1'b0, "strobe released");
        exec(mrre_op_e'(4'hf), 8'h22, 8'h44, 13'h0000);
        check_state(1'b0, 1'b0);
        $display("test freeze done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence: reset for eight cycles, then every scenario.
    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req = '{op: OP_MOV_IMM, imm: 8'h00, mem: 8'h00};
        stack_top = '0;
        err_count = 0;
        check_count = 0;
        exp_acc = ACC_RST;
        exp_fl = {4{FLAG_RST}};
        exp_wd = 8'h00;
        exp_gie = GIE_RST;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        #1;
        test_reset();
        test_rotates();
        test_subtract();
        test_moves();
        test_returns();
        test_freeze();
        finish_test();
    end

    // The run needs under 130 cycles; this limit catches a hang.
    initial begin
        repeat (3000) @(posedge clock);
        err_count++;
        $display("BAD t=%0t watchdog expired", $time);
        finish_test();
    end
endmodule
`default_nettype wire
